// File: logic/afets_map.svh
// register offsets, field positions, reset values and timing counts
// assumes an apb slave with 32-bit data, one byte register per word
// How it works
// - one global enable bit gates all timed switching
// - period is n+1 base periods, base = clock/16384
// - amplifier group starts after programmed delay ticks, tick = clock/128
// - amplifier group stays on for programmed duration ticks, then off
// - reference output has own delay and duration, same scheme
// - all timed dacs share one delay and one duration
// - comparator has own delay and duration, same scheme
// - mask bit7 comparator, bits6..3 dac3..0, bits2..0 amp2..0
// - second mask bit7 selects reference output; other bits absent
// - global enable clear: masks ignored, manual bits rule targets
// - global enable set: masked target follows sequencer only
// - global enable set: unmasked amplifier follows its manual bit
// - global enable set: unmasked dac disabled, output grounded
// - reference follows its enable bit 4, or sequencer when masked
// - reference select 00/01 internal, 10 supply, 11 floating
// - dac mode 00 hi-z off, 01/11 on, 10 grounded off
// - code bits 11..4 from high byte, 3..0 from low upper nibble
// - unimplemented bits read zero and ignore writes
// - at period end tick and base counts clear to zero, new period begins
`ifndef AFETS_MAP_SVH
`define AFETS_MAP_SVH
`define AFETS_OFS_PERIOD 12'h000
`define AFETS_OFS_AMP_DLY 12'h004
`define AFETS_OFS_AMP_DUR 12'h008
`define AFETS_OFS_REF_DLY 12'h00c
`define AFETS_OFS_REF_DUR 12'h010
`define AFETS_OFS_DAC_DLY 12'h014
`define AFETS_OFS_DAC_DUR 12'h018
`define AFETS_OFS_CMP_DLY 12'h01c
`define AFETS_OFS_CMP_DUR 12'h020
`define AFETS_OFS_TMASK 12'h024
`define AFETS_OFS_RMASK 12'h028
`define AFETS_OFS_REFCTL 12'h02c
`define AFETS_OFS_CMPCTL 12'h030
`define AFETS_OFS_AMP_BASE 12'h040
`define AFETS_OFS_DAC_BASE 12'h080
`define AFETS_DAC_STRIDE 12'h010
`define AFETS_DAC_OFS_MODE 12'h000
`define AFETS_DAC_OFS_LO 12'h004
`define AFETS_DAC_OFS_HI 12'h008
`define AFETS_BIT_GEN 7
`define AFETS_BIT_REFMASK 7
`define AFETS_BIT_REFEN 4
`define AFETS_BIT_AMPEN 5
`define AFETS_BIT_CMP_MANUAL_ENABLE 4
`define AFETS_MASK_PERIOD 8'h8f
`define AFETS_MASK_REFMASK 8'h80
`define AFETS_MASK_REFCTL 8'h13
`define AFETS_MASK_DACMODE 8'h03
`define AFETS_MASK_DACLO 8'hf0
`define AFETS_RST_REG 8'h00
`define AFETS_TICK_DIV 128
`define AFETS_BASE_DIV 16384
`endif

// File: logic/afets_pkg.sv
// types for the measurement timing sequencer
package afets_pkg;
  typedef enum logic [1:0] {
    AFETS_REF_INT0 = 2'b00,
    AFETS_REF_INT1 = 2'b01,
    AFETS_REF_SUPPLY = 2'b10,
    AFETS_REF_FLOAT = 2'b11
  } afets_ref_sel_t;
  typedef enum logic [1:0] {
    AFETS_SEQ_IDLE = 2'b00,
    AFETS_SEQ_RUN = 2'b01
  } afets_seq_state_t;
  typedef struct packed {
    logic [3:0] dac_on;
    logic [3:0] dac_ground;
    logic [2:0] amp_on;
    logic cmp_on;
    logic ref_out_on;
    logic ref_use_int;
    logic ref_use_supply;
  } afets_analog_t;
endpackage

// File: logic/afets_sequencer.sv
// measurement timing sequencer with apb register file
// assumes a 20 mhz pclk and analog macros that sample enables statically
`timescale 1ns/10ps
`include "afets_map.svh"
module afets_sequencer #(
  parameter int TICK_DIV = `AFETS_TICK_DIV,
  parameter int BASE_DIV = `AFETS_BASE_DIV
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output afets_pkg::afets_analog_t analog_ctl,
  output logic [3:0][11:0] dac_code
);
  import afets_pkg::*;

  logic [7:0] period_ff, amp_dly_ff, amp_dur_ff, ref_dly_ff, ref_dur_ff;
  logic [7:0] dac_dly_ff, dac_dur_ff, cmp_dly_ff, cmp_dur_ff;
  logic [7:0] tmask_ff, rmask_ff, refctl_ff, cmpctl_ff;
  logic [2:0][7:0] ampctl_ff;
  logic [3:0][7:0] dmode_ff, dlo_ff, dhi_ff;
  logic [3:0][11:0] dcode_ff;
  logic wr_en, rd_en, hit;
  logic [7:0] rd_byte;
  logic gen;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign gen = period_ff[`AFETS_BIT_GEN];

  // single-word decode shared by reads and writes
  always_comb begin
    hit = 1'b1;
    case (paddr)
      `AFETS_OFS_PERIOD: rd_byte = period_ff;
      `AFETS_OFS_AMP_DLY: rd_byte = amp_dly_ff;
      `AFETS_OFS_AMP_DUR: rd_byte = amp_dur_ff;
      `AFETS_OFS_REF_DLY: rd_byte = ref_dly_ff;
      `AFETS_OFS_REF_DUR: rd_byte = ref_dur_ff;
      `AFETS_OFS_DAC_DLY: rd_byte = dac_dly_ff;
      `AFETS_OFS_DAC_DUR: rd_byte = dac_dur_ff;
      `AFETS_OFS_CMP_DLY: rd_byte = cmp_dly_ff;
      `AFETS_OFS_CMP_DUR: rd_byte = cmp_dur_ff;
      `AFETS_OFS_TMASK: rd_byte = tmask_ff;
      `AFETS_OFS_RMASK: rd_byte = rmask_ff;
      `AFETS_OFS_REFCTL: rd_byte = refctl_ff;
      `AFETS_OFS_CMPCTL: rd_byte = cmpctl_ff;
      default: begin
        rd_byte = 8'h00;
        hit = 1'b0;
      end
    endcase
    for (int i = 0; i < 3; i++) begin
      if (paddr == `AFETS_OFS_AMP_BASE + 12'(4 * i)) begin
        rd_byte = ampctl_ff[i];
        hit = 1'b1;
      end
    end
    for (int m = 0; m < 4; m++) begin
      if (paddr == `AFETS_OFS_DAC_BASE + 12'(16 * m) + `AFETS_DAC_OFS_MODE) begin
        rd_byte = dmode_ff[m];
        hit = 1'b1;
      end
      if (paddr == `AFETS_OFS_DAC_BASE + 12'(16 * m) + `AFETS_DAC_OFS_LO) begin
        rd_byte = dlo_ff[m];
        hit = 1'b1;
      end
      if (paddr == `AFETS_OFS_DAC_BASE + 12'(16 * m) + `AFETS_DAC_OFS_HI) begin
        rd_byte = dhi_ff[m];
        hit = 1'b1;
      end
    end
  end

  // zero-wait slave: answer registered during setup, ready in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (rd_en) begin
        prdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // masks drop unimplemented bits on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_ff <= `AFETS_RST_REG;
      amp_dly_ff <= `AFETS_RST_REG;
      amp_dur_ff <= `AFETS_RST_REG;
      ref_dly_ff <= `AFETS_RST_REG;
      ref_dur_ff <= `AFETS_RST_REG;
      dac_dly_ff <= `AFETS_RST_REG;
      dac_dur_ff <= `AFETS_RST_REG;
      cmp_dly_ff <= `AFETS_RST_REG;
      cmp_dur_ff <= `AFETS_RST_REG;
      tmask_ff <= `AFETS_RST_REG;
      rmask_ff <= `AFETS_RST_REG;
      refctl_ff <= `AFETS_RST_REG;
      cmpctl_ff <= `AFETS_RST_REG;
    end else if (wr_en) begin
      case (paddr)
        `AFETS_OFS_PERIOD:
          period_ff <= pwdata[7:0] & `AFETS_MASK_PERIOD;
        `AFETS_OFS_AMP_DLY: amp_dly_ff <= pwdata[7:0];
        `AFETS_OFS_AMP_DUR: amp_dur_ff <= pwdata[7:0];
        `AFETS_OFS_REF_DLY: ref_dly_ff <= pwdata[7:0];
        `AFETS_OFS_REF_DUR: ref_dur_ff <= pwdata[7:0];
        `AFETS_OFS_DAC_DLY: dac_dly_ff <= pwdata[7:0];
        `AFETS_OFS_DAC_DUR: dac_dur_ff <= pwdata[7:0];
        `AFETS_OFS_CMP_DLY: cmp_dly_ff <= pwdata[7:0];
        `AFETS_OFS_CMP_DUR: cmp_dur_ff <= pwdata[7:0];
        `AFETS_OFS_TMASK: tmask_ff <= pwdata[7:0];
        `AFETS_OFS_RMASK:
          rmask_ff <= pwdata[7:0] & `AFETS_MASK_REFMASK;
        `AFETS_OFS_REFCTL:
          refctl_ff <= pwdata[7:0] & `AFETS_MASK_REFCTL;
        `AFETS_OFS_CMPCTL: cmpctl_ff <= pwdata[7:0] & 8'h10;
        default: ;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_amp
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ampctl_ff[g] <= `AFETS_RST_REG;
        end else if (wr_en && paddr == `AFETS_OFS_AMP_BASE + 12'(4 * g)) begin
          ampctl_ff[g] <= pwdata[7:0] & 8'h20;
        end
      end
    end
    for (g = 0; g < 4; g++) begin : g_dac
      localparam logic [11:0] BASE = `AFETS_OFS_DAC_BASE + 12'(16 * g);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dmode_ff[g] <= `AFETS_RST_REG;
          dlo_ff[g] <= `AFETS_RST_REG;
          dhi_ff[g] <= `AFETS_RST_REG;
          dcode_ff[g] <= 12'h000;
        end else if (wr_en) begin
          if (paddr == BASE + `AFETS_DAC_OFS_MODE) begin
            dmode_ff[g] <= pwdata[7:0] & `AFETS_MASK_DACMODE;
          end
          if (paddr == BASE + `AFETS_DAC_OFS_LO) begin
            dlo_ff[g] <= pwdata[7:0] & `AFETS_MASK_DACLO;
          end
          // low byte must come first; the high write commits both
          if (paddr == BASE + `AFETS_DAC_OFS_HI) begin
            dhi_ff[g] <= pwdata[7:0];
            dcode_ff[g] <= {pwdata[7:0], dlo_ff[g][7:4]};
          end
        end
      end
    end
  endgenerate

  // tick and base prescalers from one counter; base divides by tick
  logic [13:0] pre_ff;
  logic tick, base;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= 14'h0000;
    end else if (!gen) begin
      pre_ff <= 14'h0000;
    end else begin
      pre_ff <= (pre_ff == 14'(BASE_DIV - 1)) ? 14'h0000 : pre_ff + 14'h0001;
    end
  end
  // tick divider must be a power of two so the low bits alone mark it
  assign tick = gen &&
                ((pre_ff & 14'(TICK_DIV - 1)) == 14'(TICK_DIV - 1));
  assign base = gen && (pre_ff == 14'(BASE_DIV - 1));

  afets_seq_state_t state_ff;
  logic [3:0] bcnt_ff;
  logic [8:0] tcnt_ff;
  logic period_end;
  assign period_end = base && (bcnt_ff == period_ff[3:0]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= AFETS_SEQ_IDLE;
      bcnt_ff <= 4'h0;
      tcnt_ff <= 9'h000;
    end else begin
      case (state_ff)
        AFETS_SEQ_IDLE: begin
          bcnt_ff <= 4'h0;
          tcnt_ff <= 9'h000;
          if (gen) begin
            state_ff <= AFETS_SEQ_RUN;
          end
        end
        AFETS_SEQ_RUN: begin
          if (!gen) begin
            state_ff <= AFETS_SEQ_IDLE;
          end else if (period_end) begin
            bcnt_ff <= 4'h0;
            tcnt_ff <= 9'h000;
          end else begin
            if (base) begin
              bcnt_ff <= bcnt_ff + 4'h1;
            end
            if (tick && tcnt_ff != 9'h1ff) begin
              tcnt_ff <= tcnt_ff + 9'h001;
            end
          end
        end
        default: state_ff <= AFETS_SEQ_IDLE;
      endcase
    end
  end

  // window test: on while delay <= ticks < delay + duration
  function automatic logic in_win(input logic [8:0] t, input logic [7:0] d,
                                  input logic [7:0] l);
    logic [8:0] e;
    e = {1'b0, d} + {1'b0, l};
    return (t >= {1'b0, d}) && (t < e);
  endfunction

  logic running, w_amp, w_ref, w_dac, w_cmp;
  assign running = (state_ff == AFETS_SEQ_RUN) && gen;
  assign w_amp = running &&
                 in_win(tcnt_ff, amp_dly_ff, amp_dur_ff);
  assign w_ref = running &&
                 in_win(tcnt_ff, ref_dly_ff, ref_dur_ff);
  assign w_dac = running &&
                 in_win(tcnt_ff, dac_dly_ff, dac_dur_ff);
  assign w_cmp = running &&
                 in_win(tcnt_ff, cmp_dly_ff, cmp_dur_ff);

  afets_analog_t nxt_ana;
  always_comb begin
    for (int n = 0; n < 3; n++) begin
      if (gen && tmask_ff[n]) begin
        nxt_ana.amp_on[n] = w_amp;
      end else begin
        nxt_ana.amp_on[n] = ampctl_ff[n][`AFETS_BIT_AMPEN];
      end
    end
    for (int m = 0; m < 4; m++) begin
      if (gen) begin
        nxt_ana.dac_on[m] = tmask_ff[3+m] & w_dac;
        nxt_ana.dac_ground[m] = ~nxt_ana.dac_on[m];
      end else begin
        nxt_ana.dac_on[m] = dmode_ff[m][0];
        nxt_ana.dac_ground[m] = (dmode_ff[m][1:0] == 2'b10);
      end
    end
    nxt_ana.cmp_on = (gen && tmask_ff[7]) ? w_cmp :
                     cmpctl_ff[`AFETS_BIT_CMP_MANUAL_ENABLE];
    nxt_ana.ref_out_on = (gen && rmask_ff[`AFETS_BIT_REFMASK]) ? w_ref :
                         refctl_ff[`AFETS_BIT_REFEN];
    case (afets_ref_sel_t'(refctl_ff[1:0]))
      AFETS_REF_INT0, AFETS_REF_INT1: begin
        nxt_ana.ref_use_int = 1'b1;
        nxt_ana.ref_use_supply = 1'b0;
      end
      AFETS_REF_SUPPLY: begin
        nxt_ana.ref_use_int = 1'b0;
        nxt_ana.ref_use_supply = 1'b1;
      end
      default: begin
        nxt_ana.ref_use_int = 1'b0;
        nxt_ana.ref_use_supply = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_ctl <= '0;
      dac_code <= '0;
    end else begin
      analog_ctl <= nxt_ana;
      dac_code <= dcode_ff;
    end
  end

  amp_off_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gen && tmask_ff[0] && !w_amp) |=> !analog_ctl.amp_on[0])
    else $error("masked amplifier on outside its window");
  manual_amp_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!gen) |=> analog_ctl.amp_on[1] == $past(ampctl_ff[1][5]))
    else $error("amplifier ignores manual bit");
  dac_ground_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gen && !tmask_ff[3]) |=> (!analog_ctl.dac_on[0] &&
    analog_ctl.dac_ground[0]))
    else $error("unmasked dac not grounded");
  period_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (running && period_end) |=> (tcnt_ff == 9'h000 && bcnt_ff == 4'h0))
    else $error("period end did not restart counters");
  tick_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (running && !base && tick && tcnt_ff < 9'h100) |=>
    tcnt_ff == $past(tcnt_ff) + 9'h001)
    else $error("tick count did not advance");
  gen_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!gen) |=> (state_ff == AFETS_SEQ_IDLE))
    else $error("sequencer runs while disabled");
  zero_dur_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gen && tmask_ff[7] && cmp_dur_ff == 8'h00) |=> !analog_ctl.cmp_on)
    else $error("zero duration comparator turned on");
  ref_float_a: assert property (@(posedge pclk) disable iff (!presetn)
    (refctl_ff[1:0] == 2'b11) |=> !(analog_ctl.ref_use_int ||
    analog_ctl.ref_use_supply))
    else $error("floating reference still driven");
  code_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == `AFETS_OFS_DAC_BASE + `AFETS_DAC_OFS_HI) |=> ##1
    dac_code[0] == {$past(pwdata[7:0], 2), $past(dlo_ff[0][7:4], 2)})
    else $error("dac code not committed from high write");
  dac_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!gen && dmode_ff[2][1:0] == 2'b10) |=> (!analog_ctl.dac_on[2] &&
    analog_ctl.dac_ground[2]))
    else $error("dac mode 10 not grounded");
endmodule

// File: dv/afets_analog_model.sv
// partner: analog dacs and reference driven by the sequencer outputs
// assumes enables and codes arrive as static levels from the block
`timescale 1ns/10ps
module afets_analog_model #(
  parameter int REF_INT = 1200,
  parameter int REF_SUP = 3300
) (
  input wire afets_pkg::afets_analog_t analog_ctl,
  input wire logic [3:0][11:0] dac_code,
  output logic [3:0][15:0] dac_level
);
  import afets_pkg::*;
  int vref;
  always_comb begin
    vref = analog_ctl.ref_use_int ? REF_INT : 0;
    if (analog_ctl.ref_use_supply) vref = REF_SUP;
    for (int m = 0; m < 4; m++) begin
      // hi-z has no pull: show all ones, never a stale level
      dac_level[m] = analog_ctl.dac_ground[m] ? 16'h0000 : 16'hffff;
      if (analog_ctl.dac_on[m])
        dac_level[m] = 16'(vref * dac_code[m] / 4096);
    end
  end
endmodule

// File: dv/afe_measurement_timing_sequencer_test.sv
// self-checking bench for the measurement timing sequencer over apb
// assumes short dividers so whole sequence periods fit in the run
`timescale 1ns/10ps
module afe_measurement_timing_sequencer_test;
  import afets_pkg::*;
  localparam int TICK = 4;
  localparam int BASE = 64;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  afets_analog_t actl;
  logic [3:0][11:0] dac_code;
  logic [3:0][15:0] dac_level;
  logic [11:0] wa [7] = '{12'h000, 12'h028, 12'h02c, 12'h080, 12'h084,
    12'h040, 12'h024};
  logic [7:0] we [7] = '{8'h8f, 8'h80, 8'h13, 8'h03, 8'hf0, 8'h20, 8'hff};
  logic [7:0] cfg [8] = '{8'h02, 8'h03, 8'h01, 8'hff, 8'h00, 8'h01,
    8'h03, 8'h02};
  int num_errors = 0;
  int comparisons = 0;
  int bad = 0;

  afets_sequencer #(.TICK_DIV(TICK), .BASE_DIV(BASE)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .analog_ctl(actl),
    .dac_code(dac_code));
  afets_analog_model model (.analog_ctl(actl), .dac_code(dac_code),
    .dac_level(dac_level));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one idle edge after release so the next setup never lands on it
  task automatic xfer(input logic [11:0] a, input logic w,
      input logic [7:0] d);
    int n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    if (n == 16) num_errors++;
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    xfer(a, 1'b0, 8'h00);
    check(rd_data, {24'h0, exp});
  endtask

  task automatic measure(input int n);
    int p, k, t, ca = 0, cd = 0, cr = 0, cc = 0, rises = 0;
    int ra = 0, rd0 = 0, rr = 0, rc = 0, b6 = 0, b12 = 0, b13 = 0;
    afets_analog_t prev;
    p = BASE * (n + 1);
    k = 2048 / p;
    t = p / TICK;
    wr(12'h000, 8'h00);
    wr(12'h000, 8'h80 | 8'(n));
    cyc(2 * p);
    prev = actl;
    for (int i = 0; i < 2048; i++) begin
      @(posedge pclk);
      ca += actl.amp_on[0];
      cd += actl.dac_on[0];
      cr += actl.ref_out_on;
      cc += actl.cmp_on;
      if (actl.amp_on[0] && !prev.amp_on[0]) rises++;
      if (actl.amp_on[0] && !prev.amp_on[0]) ra = i;
      if (actl.dac_on[0] && !prev.dac_on[0]) rd0 = i;
      if (actl.ref_out_on && !prev.ref_out_on) rr = i;
      if (actl.cmp_on && !prev.cmp_on) rc = i;
      if (actl.dac_on[2:0] !== {3{actl.dac_on[0]}}) b6++;
      if (actl.amp_on[2:1] !== 2'b01) b12++;
      if (actl.dac_on[3] !== 1'b0 || actl.dac_ground[3] !== 1'b1) b13++;
      prev = actl;
    end
    check(rises, k);
    check(ca, k * 3 * TICK);
    check(cd, k * TICK);
    check(cc, k * 2 * TICK);
    check(cr, k * TICK * ((t - 1 < 255) ? t - 1 : 255));
    check((ra - rd0 + p) % p, 2 * TICK);
    check((rr - rd0 + p) % p, TICK);
    check((rc - rd0 + p) % p, 3 * TICK);
    check(b6, 0);
    check(b12, 0);
    check(b13, 0);
    $display("sequencer test period %0d done", n);
  endtask

  initial begin
    #(50 * 60000);
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    conclude();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 13; i++) rd(12'(4 * i), 8'h00);
    for (int m = 0; m < 4; m++) rd(12'h088 + 12'(16 * m), 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(wa[i], 8'hff);
      rd(wa[i], we[i]);
    end
    xfer(12'hffc, 1'b0, 8'h00);
    check(rd_err, 1'b1);
    check(rd_data, 32'h0);
    $display("register test done");
    wr(12'h000, 8'h00);
    wr(12'h084, 8'ha0);
    cyc(3);
    check(dac_code[0], 12'h000);
    wr(12'h088, 8'h5c);
    cyc(3);
    check(dac_code[0], 12'h5ca);
    wr(12'h080, 8'h01);
    wr(12'h02c, 8'h00);
    cyc(3);
    check(dac_level[0], 16'(1200 * 32'h5ca / 4096));
    $display("dac code test done");
    wr(12'h028, 8'h80);
    for (int m = 0; m < 4; m++) wr(12'h080 + 12'(16 * m), 8'(m));
    wr(12'h044, 8'h00);
    wr(12'h048, 8'h20);
    wr(12'h030, 8'h10);
    for (int s = 0; s < 4; s++) begin
      wr(12'h02c, 8'h10 | 8'(s));
      cyc(3);
      check(actl.ref_use_int, s < 2);
      check(actl.ref_use_supply, s == 2);
    end
    check(actl.dac_on, 4'b1010);
    check(actl.dac_ground, 4'b0100);
    check(actl.amp_on, 3'b101);
    check(actl.cmp_on, 1'b1);
    check(actl.ref_out_on, 1'b1);
    $display("manual test done");
    wr(12'h02c, 8'h00);
    wr(12'h030, 8'h00);
    wr(12'h040, 8'h00);
    wr(12'h044, 8'h20);
    wr(12'h048, 8'h00);
    wr(12'h024, 8'hb9);
    for (int i = 0; i < 8; i++) wr(12'(4 + 4 * i), cfg[i]);
    measure(0);
    measure(1);
    measure(15);
    wr(12'h000, 8'h0f);
    for (int i = 0; i < 300; i++) begin
      @(posedge pclk);
      if (actl.amp_on[0] !== 1'b0 || actl.ref_out_on !== 1'b0) bad++;
    end
    check(bad, 0);
    check(actl.dac_on[3], 1'b1);
    $display("disable test done");
    conclude();
  end
endmodule
